/* File: src/edw_map.svh */
// Constants for the execution dispatch and writeback control block
`ifndef EDW_MAP_SVH
`define EDW_MAP_SVH

// ==========================================================
// Structure
`define EDW_NUM_PORTS   6
`define EDW_NUM_STACKS  3
`define EDW_WB_DEPTH    8
`define EDW_LAT_W       3
`define EDW_BUS_W       5
`define EDW_CNT_W       3

// ==========================================================
// Transfer micro-op ports and bypass delays in cycles
`define EDW_XFER_PORT0  3'h0
`define EDW_XFER_PORT5  3'h5
`define EDW_DLY_NONE    2'h0
`define EDW_DLY_ONE     2'h1
`define EDW_DLY_TWO     2'h2

// ==========================================================
// Reset value and minimum latency
`define EDW_RST_RESV    8'h00
`define EDW_LAT_MIN     3'h1

`endif

/* File: src/edw_pkg.sv */
// Types shared by the execution dispatch and writeback control block
`include "edw_map.svh"

package edw_pkg;

  // ==========================================================
  // Micro-op kinds
  typedef enum logic [3:0] {
    EDW_OP_ALU         = 4'h0,
    EDW_OP_SHIFT       = 4'h1,
    EDW_OP_LEA_FAST    = 4'h2,
    EDW_OP_LEA_SLOW    = 4'h3,
    EDW_OP_MUL         = 4'h4,
    EDW_OP_LOAD_ADDR   = 4'h5,
    EDW_OP_STORE_ADDR  = 4'h6,
    EDW_OP_STORE_DATA  = 4'h7,
    EDW_OP_BRANCH      = 4'h8,
    EDW_OP_DIV         = 4'h9,
    EDW_OP_BLEND       = 4'hA,
    EDW_OP_SHUF        = 4'hB,
    EDW_OP_ADD         = 4'hC,
    EDW_OP_CVT         = 4'hD,
    EDW_OP_MOV         = 4'hE,
    EDW_OP_STRCMP      = 4'hF
  } edw_op_e;

  // ==========================================================
  // Data classes of results and sources
  typedef enum logic [1:0] {
    EDW_CLS_INT   = 2'h0,   // General integer stack
    EDW_CLS_VINT  = 2'h1,   // Vector integer, vector stack
    EDW_CLS_FP_LO = 2'h2,   // Vector float and wide_fp_lower_half, vector stack
    EDW_CLS_FP_HI = 2'h3    // x87 and wide_fp_upper_half, x87 stack
  } edw_cls_e;

  // ==========================================================
  // Registered state of the dispatch control
  typedef struct packed {
    logic [`EDW_NUM_PORTS-1:0]                  issue;
    logic [`EDW_NUM_PORTS-1:0]                  hold;
    logic [`EDW_NUM_PORTS-1:0]                  illegal;
    logic [`EDW_NUM_PORTS-1:0][`EDW_BUS_W-1:0]  wb_bus;
    logic [`EDW_NUM_PORTS-1:0][1:0]             byp_dly;
    logic [`EDW_NUM_PORTS-1:0]                  xfer;
    logic [`EDW_NUM_PORTS-1:0][2:0]             xfer_port;
    logic [`EDW_NUM_PORTS-1:0]                  assist;
    logic [`EDW_CNT_W-1:0]                      count;
  } edw_state_s;

  // Reservation window of one writeback bus
  typedef struct packed {
    logic [`EDW_WB_DEPTH-1:0] resv;
  } edw_slot_s;

endpackage

/* File: src/edw_wb_slot.sv */
// Reservation window of one writeback bus (one port, one stack)
`timescale 1ns/100ps
`include "edw_map.svh"

module edw_wb_slot (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // Reservation request
  input  wire logic                  reserve,
  input  wire logic [`EDW_LAT_W-1:0] lat,
  // Status
  output logic                       busy,
  output logic                       idle
);

  edw_pkg::edw_slot_s st_q;
  edw_pkg::edw_slot_s st_d;

  // Bit k of the window means the bus is taken k cycles after this one
  assign busy = st_q.resv[lat];
  assign idle = (st_q.resv == `EDW_RST_RESV);

  // Age the window and book the result cycle of a new micro-op
  always_comb
  begin
    st_d      = st_q;
    st_d.resv = {1'b0, st_q.resv[`EDW_WB_DEPTH-1:1]};
    if (reserve)
    begin
      st_d.resv[lat - `EDW_LAT_MIN] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '{resv: `EDW_RST_RESV};
    else
      st_q <= st_d;
  end

endmodule

/* File: src/edw_dispatch.sv */
// Dispatch, writeback bus arbitration and bypass delay control
// Function
// [RULE1] At most six micro-ops, one per port
// [RULE2] Three stacks: integer, vector, x87
// [RULE3] Integer operations steered to fixed ports
// [RULE4] Result bus chosen by port and class
// [RULE5] Writeback bus clash holds one micro-op back
// [RULE6] Port 0 multiply then blend collides
// [RULE7] Integer add after float multiply: no clash
// [RULE8] Cross-stack source adds one or two cycles; code adds zero or one
// [RULE9] Cross-stack moves insert port 0/5 micro-op; code inserts none between vector int and x87
// [RULE10] Same-stack zero; vector int/float one cycle
// [RULE11] Load delay: int 0, vector 1, x87 2
// [RULE12] Denormal handling without assist, flush controls clear; code still assists float ops other than add, multiply, divide, convert
// [RULE13] Scheduler picks micro-ops by readiness, priority
// [RULE14] Earlier micro-op keeps bus; later waits
`timescale 1ns/100ps
`include "edw_map.svh"

module edw_dispatch (
  // Clock and reset
  input  wire logic                                      core_clk,
  input  wire logic                                      rst_b,
  // Dispatch requests from the scheduler, one lane per port
  input  wire logic [`EDW_NUM_PORTS-1:0]                 req_valid,
  input  wire logic [`EDW_NUM_PORTS-1:0][3:0]            req_op,
  input  wire logic [`EDW_NUM_PORTS-1:0][1:0]            req_cls,
  input  wire logic [`EDW_NUM_PORTS-1:0][`EDW_LAT_W-1:0] req_lat,
  input  wire logic [`EDW_NUM_PORTS-1:0][1:0]            req_src_cls,
  input  wire logic [`EDW_NUM_PORTS-1:0]                 req_src_load,
  input  wire logic [`EDW_NUM_PORTS-1:0]                 req_denorm,
  // Floating-point control
  input  wire logic                                      flush_underflow_to_zero,
  input  wire logic                                      denormal_inputs_as_zero,
  // Dispatch results
  output logic [`EDW_NUM_PORTS-1:0]                      issue,
  output logic [`EDW_NUM_PORTS-1:0]                      hold,
  output logic [`EDW_NUM_PORTS-1:0]                      illegal,
  output logic [`EDW_NUM_PORTS-1:0][`EDW_BUS_W-1:0]      wb_bus,
  output logic [`EDW_CNT_W-1:0]                          issue_count,
  // Bypass and assist results
  output logic [`EDW_NUM_PORTS-1:0][1:0]                 byp_dly,
  output logic [`EDW_NUM_PORTS-1:0]                      xfer,
  output logic [`EDW_NUM_PORTS-1:0][2:0]                 xfer_port,
  output logic [`EDW_NUM_PORTS-1:0]                      assist
);

  // ==========================================================
  // Declarations
  edw_pkg::edw_state_s                         st_q;
  edw_pkg::edw_state_s                         st_d;
  logic [`EDW_NUM_PORTS-1:0][`EDW_LAT_W-1:0]   lat_c;
  logic [`EDW_NUM_PORTS-1:0][1:0]              stk;
  logic [`EDW_NUM_PORTS-1:0]                   legal;
  logic [`EDW_NUM_PORTS-1:0]                   go;
  logic [`EDW_NUM_PORTS-1:0]                   clash;
  logic [`EDW_NUM_PORTS-1:0][`EDW_NUM_STACKS-1:0] busy_v;
  logic [`EDW_NUM_PORTS-1:0][`EDW_NUM_STACKS-1:0] idle_v;

  // ==========================================================
  // Port capability table
  function automatic logic op_ok(input logic [2:0] p,
                                 input edw_pkg::edw_cls_e c,
                                 input edw_pkg::edw_op_e o);
    logic ok;
    ok = 1'b0;
    if (p == 3'h4)
      ok = (o == edw_pkg::EDW_OP_STORE_DATA);
    else if (c == edw_pkg::EDW_CLS_INT)
    begin
      unique case (p)
        3'h0: ok = o inside {edw_pkg::EDW_OP_ALU, edw_pkg::EDW_OP_SHIFT}; // RULE3
        3'h1: ok = o inside {edw_pkg::EDW_OP_ALU, edw_pkg::EDW_OP_LEA_FAST,
                             edw_pkg::EDW_OP_LEA_SLOW, edw_pkg::EDW_OP_MUL}; // RULE3
        3'h2,
        3'h3: ok = o inside {edw_pkg::EDW_OP_LOAD_ADDR, edw_pkg::EDW_OP_STORE_ADDR}; // RULE3
        3'h5: ok = o inside {edw_pkg::EDW_OP_ALU, edw_pkg::EDW_OP_SHIFT,
                             edw_pkg::EDW_OP_BRANCH, edw_pkg::EDW_OP_LEA_FAST}; // RULE3
        default: ok = 1'b0;
      endcase
    end
    else if (c == edw_pkg::EDW_CLS_VINT)
    begin
      unique case (p)
        3'h0: ok = o inside {edw_pkg::EDW_OP_MUL, edw_pkg::EDW_OP_SHIFT, edw_pkg::EDW_OP_DIV,
                             edw_pkg::EDW_OP_STRCMP, edw_pkg::EDW_OP_MOV};
        3'h1: ok = o inside {edw_pkg::EDW_OP_ALU, edw_pkg::EDW_OP_SHUF,
                             edw_pkg::EDW_OP_BLEND, edw_pkg::EDW_OP_MOV};
        3'h5: ok = o inside {edw_pkg::EDW_OP_ALU, edw_pkg::EDW_OP_SHUF, edw_pkg::EDW_OP_SHIFT,
                             edw_pkg::EDW_OP_BLEND, edw_pkg::EDW_OP_MOV};
        default: ok = 1'b0;
      endcase
    end
    else
    begin
      // Both float halves share one capability row
      unique case (p)
        3'h0: ok = o inside {edw_pkg::EDW_OP_MUL, edw_pkg::EDW_OP_DIV,
                             edw_pkg::EDW_OP_BLEND, edw_pkg::EDW_OP_MOV};
        3'h1: ok = o inside {edw_pkg::EDW_OP_ADD, edw_pkg::EDW_OP_CVT};
        3'h5: ok = o inside {edw_pkg::EDW_OP_SHUF, edw_pkg::EDW_OP_BLEND, edw_pkg::EDW_OP_MOV};
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Stack that holds a data class
  function automatic logic [1:0] stack_of(input edw_pkg::edw_cls_e c);
    logic [1:0] s;
    s = 2'h0;
    unique case (c)
      edw_pkg::EDW_CLS_INT:   s = 2'h0; // RULE2
      edw_pkg::EDW_CLS_VINT,
      edw_pkg::EDW_CLS_FP_LO: s = 2'h1; // RULE2
      edw_pkg::EDW_CLS_FP_HI: s = 2'h2; // RULE2
    endcase
    return s;
  endfunction

  // Bypass cost: {transfer micro-op, on port 5, extra delay}
  function automatic logic [3:0] bypass(input logic ld,
                                        input edw_pkg::edw_cls_e s,
                                        input edw_pkg::edw_cls_e d);
    logic [3:0] r;
    r = {2'b00, `EDW_DLY_NONE};
    if (ld)
    begin
      unique case (d)
        edw_pkg::EDW_CLS_INT:   r = {2'b00, `EDW_DLY_NONE}; // RULE11
        edw_pkg::EDW_CLS_VINT,
        edw_pkg::EDW_CLS_FP_LO: r = {2'b00, `EDW_DLY_ONE};  // RULE11
        edw_pkg::EDW_CLS_FP_HI: r = {2'b00, `EDW_DLY_TWO};  // RULE11
      endcase
    end
    else if (s == d)
      r = {2'b00, `EDW_DLY_NONE}; // RULE10
    else if (s == edw_pkg::EDW_CLS_INT)
      r = (d == edw_pkg::EDW_CLS_FP_HI) ? {2'b10, `EDW_DLY_ONE}
                                        : {2'b10, `EDW_DLY_NONE}; // RULE9
    else if (d == edw_pkg::EDW_CLS_INT)
      r = (s == edw_pkg::EDW_CLS_FP_HI) ? {2'b11, `EDW_DLY_ONE}
                                        : {2'b11, `EDW_DLY_NONE}; // RULE9
    else if (s == edw_pkg::EDW_CLS_VINT || d == edw_pkg::EDW_CLS_VINT)
      // Vector integer meets either float class directly
      r = (s == edw_pkg::EDW_CLS_FP_LO || d == edw_pkg::EDW_CLS_FP_LO)
          ? {2'b00, `EDW_DLY_ONE} : {2'b00, `EDW_DLY_NONE}; // RULE8 RULE10
    else
      r = {2'b11, `EDW_DLY_ONE}; // RULE10
    return r;
  endfunction

  // ==========================================================
  // Writeback bus windows, one per port and stack
  for (genvar p = 0; p < `EDW_NUM_PORTS; p++)
  begin : g_port
    for (genvar s = 0; s < `EDW_NUM_STACKS; s++)
    begin : g_stk
      edw_wb_slot u_slot (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .reserve  (go[p] && (stk[p] == 2'(s))),
        .lat      (lat_c[p]),
        .busy     (busy_v[p][s]),
        .idle     (idle_v[p][s])
      );
    end
  end

  // Per-port decode; a zero latency is taken as one cycle
  always_comb
  begin
    for (int p = 0; p < `EDW_NUM_PORTS; p++)
    begin
      lat_c[p] = (req_lat[p] == 3'h0) ? `EDW_LAT_MIN : req_lat[p];
      stk[p]   = stack_of(edw_pkg::edw_cls_e'(req_cls[p]));
      legal[p] = op_ok(3'(p), edw_pkg::edw_cls_e'(req_cls[p]), edw_pkg::edw_op_e'(req_op[p]));
      // Only the bus of the result's own stack counts
      clash[p] = busy_v[p][stk[p]]; // RULE5 RULE6 RULE7
      go[p]    = req_valid[p] && legal[p] && !clash[p]; // RULE1 RULE14
    end
  end

  // ==========================================================
  // Next state; the booked earlier micro-op always keeps its bus
  always_comb
  begin
    logic [3:0] b;
    logic       fp;
    st_d       = st_q;
    st_d.count = '0;
    b          = 4'h0;
    fp         = 1'b0;
    for (int p = 0; p < `EDW_NUM_PORTS; p++)
    begin
      st_d.issue[p]   = go[p]; // RULE1
      st_d.hold[p]    = req_valid[p] && legal[p] && clash[p]; // RULE5 RULE14
      st_d.illegal[p] = req_valid[p] && !legal[p]; // RULE3
      st_d.wb_bus[p]  = 5'(p * `EDW_NUM_STACKS) + {3'h0, stk[p]}; // RULE4
      b = bypass(req_src_load[p], edw_pkg::edw_cls_e'(req_src_cls[p]),
                 edw_pkg::edw_cls_e'(req_cls[p]));
      st_d.xfer[p]      = go[p] && b[3]; // RULE9
      st_d.xfer_port[p] = b[2] ? `EDW_XFER_PORT5 : `EDW_XFER_PORT0; // RULE9
      st_d.byp_dly[p]   = b[1:0]; // RULE8
      // Hardware handles these float ops when flushing is off
      fp = (req_cls[p] != 2'(edw_pkg::EDW_CLS_INT)) && (req_cls[p] != 2'(edw_pkg::EDW_CLS_VINT));
      st_d.assist[p] = go[p] && fp && req_denorm[p]
                       && !flush_underflow_to_zero && !denormal_inputs_as_zero
                       && !(req_op[p] inside {4'(edw_pkg::EDW_OP_ADD), 4'(edw_pkg::EDW_OP_MUL),
                                              4'(edw_pkg::EDW_OP_DIV), 4'(edw_pkg::EDW_OP_CVT)}); // RULE12
      st_d.count = st_d.count + 3'(go[p]); // RULE1
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Outputs straight from the state register
  assign issue       = st_q.issue;
  assign hold        = st_q.hold;
  assign illegal     = st_q.illegal;
  assign wb_bus      = st_q.wb_bus;
  assign issue_count = st_q.count;
  assign byp_dly     = st_q.byp_dly;
  assign xfer        = st_q.xfer;
  assign xfer_port   = st_q.xfer_port;
  assign assist      = st_q.assist;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_issue_count;
    issue_count == 3'($countones(issue));
  endproperty
  a_issue_count: assert property (p_issue_count) else $error("issue count mismatch"); // RULE1

  property p_stack_bus;
    (req_valid[1] && req_cls[1] == 2'(edw_pkg::EDW_CLS_FP_HI)) |=> (wb_bus[1] == 5'h05);
  endproperty
  a_stack_bus: assert property (p_stack_bus) else $error("x87 result on wrong bus"); // RULE2 RULE4

  property p_store_data_port;
    (req_valid[4] && req_op[4] != 4'(edw_pkg::EDW_OP_STORE_DATA)) |=> (illegal[4] && !issue[4]);
  endproperty
  a_store_data_port: assert property (p_store_data_port) else $error("port 4 accepted bad op"); // RULE3

  property p_mul_blend;
    (go[0] && req_cls[0] == 2'(edw_pkg::EDW_CLS_FP_LO) && lat_c[0] == 3'h5) ##4
    (req_valid[0] && legal[0] && req_cls[0] == 2'(edw_pkg::EDW_CLS_FP_LO) && lat_c[0] == 3'h1)
    |=> (hold[0] && !issue[0]);
  endproperty
  a_mul_blend: assert property (p_mul_blend) else $error("multiply and blend not held"); // RULE6

  property p_mul_add;
    (go[0] && req_cls[0] == 2'(edw_pkg::EDW_CLS_FP_LO) && lat_c[0] == 3'h5) ##4
    (req_valid[0] && legal[0] && req_cls[0] == 2'(edw_pkg::EDW_CLS_INT) && lat_c[0] == 3'h1
     && idle_v[0][0] && $past(idle_v[0][0], 4))
    |=> (issue[0] && !hold[0]);
  endproperty
  a_mul_add: assert property (p_mul_add) else $error("integer add wrongly held"); // RULE7

  property p_hold_earlier;
    (req_valid[2] && legal[2] && clash[2]) |=> (hold[2] && !issue[2]);
  endproperty
  a_hold_earlier: assert property (p_hold_earlier) else $error("clash not held"); // RULE5 RULE14

  property p_vint_fp;
    (!req_src_load[3] && req_src_cls[3] == 2'(edw_pkg::EDW_CLS_VINT)
     && req_cls[3] == 2'(edw_pkg::EDW_CLS_FP_LO)) |=> (byp_dly[3] == 2'h1 && !xfer[3]);
  endproperty
  a_vint_fp: assert property (p_vint_fp) else $error("vector int to float delay wrong"); // RULE8 RULE10

  property p_int_to_vec;
    (go[5] && !req_src_load[5] && req_src_cls[5] == 2'(edw_pkg::EDW_CLS_INT)
     && req_cls[5] == 2'(edw_pkg::EDW_CLS_VINT)) |=> (xfer[5] && xfer_port[5] == 3'h0);
  endproperty
  a_int_to_vec: assert property (p_int_to_vec) else $error("missing port 0 transfer"); // RULE9

  property p_load_x87;
    (req_src_load[0] && req_cls[0] == 2'(edw_pkg::EDW_CLS_FP_HI)) |=> (byp_dly[0] == 2'h2);
  endproperty
  a_load_x87: assert property (p_load_x87) else $error("load to x87 delay wrong"); // RULE11

  property p_no_assist;
    (go[1] && req_op[1] == 4'(edw_pkg::EDW_OP_ADD) && !flush_underflow_to_zero
     && !denormal_inputs_as_zero) |=> !assist[1];
  endproperty
  a_no_assist: assert property (p_no_assist) else $error("assist on float add"); // RULE12

endmodule

/* File: verif/edw_sched_model.sv */
// Scheduler model that feeds requests to the dispatch control
`timescale 1ns/100ps
`include "edw_map.svh"

module edw_sched_model (
  // Clock and reset
  input  wire logic                                      core_clk,
  input  wire logic                                      rst_b,
  // Lanes wanted by the bench: valid, op, class, latency, source, load, denormal
  input  wire logic [`EDW_NUM_PORTS-1:0][13:0]           want,
  // Clash feedback from the dispatch control
  input  wire logic [`EDW_NUM_PORTS-1:0]                 hold,
  // Requests offered each cycle
  output logic [`EDW_NUM_PORTS-1:0]                      req_valid,
  output logic [`EDW_NUM_PORTS-1:0][3:0]                 req_op,
  output logic [`EDW_NUM_PORTS-1:0][1:0]                 req_cls,
  output logic [`EDW_NUM_PORTS-1:0][`EDW_LAT_W-1:0]      req_lat,
  output logic [`EDW_NUM_PORTS-1:0][1:0]                 req_src_cls,
  output logic [`EDW_NUM_PORTS-1:0]                      req_src_load,
  output logic [`EDW_NUM_PORTS-1:0]                      req_denorm
);
  // ========
  // Lane selection
  logic [`EDW_NUM_PORTS-1:0][13:0] pick;
  logic [`EDW_NUM_PORTS-1:0][13:0] last_q;

  // A held lane goes again first, so a refused micro-op is never lost
  always_comb
  begin
    for (int p = 0; p < `EDW_NUM_PORTS; p++)
    begin
      pick[p] = hold[p] ? last_q[p] : want[p];
      {req_valid[p], req_op[p], req_cls[p], req_lat[p]} = pick[p][13:4];
      {req_src_cls[p], req_src_load[p], req_denorm[p]} = pick[p][3:0];
    end
  end

  // Remember what was offered, in case it comes back held
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      last_q <= '0;
    else
      last_q <= pick;
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the dispatch and writeback control
`timescale 1ns/100ps
`include "edw_map.svh"

module tb_top;
  // ========
  // Clock, reset and nets
  logic                 core_clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 flush_underflow_to_zero = 1'b0;
  logic                 denormal_inputs_as_zero = 1'b0;
  logic [5:0][13:0]     want = '0;
  logic [5:0]           req_valid, req_src_load, req_denorm, hold, issue, illegal, xfer, assist;
  logic [5:0][3:0]      req_op;
  logic [5:0][1:0]      req_cls, req_src_cls, byp_dly;
  logic [5:0][2:0]      req_lat, xfer_port;
  logic [5:0][4:0]      wb_bus;
  logic [2:0]           issue_count;
  logic [5:0]           e_issue, e_hold, e_ill, e_xfer, e_assist;
  logic [5:0][1:0]      e_dly;
  logic [5:0][4:0]      e_bus;
  logic [5:0][2:0]      e_xp;
  logic [7:0]           slot [6][3];
  logic [15:0]          seed = 16'h41CC;
  int                   miscompares = 0;
  int                   comparisons = 0;
  // Legal ops per class row (int, vector int, float) and port
  localparam logic [15:0] cap_tbl [3][6] = '{
    '{16'h0003, 16'h001D, 16'h0060, 16'h0060, 16'h0080, 16'h0107},
    '{16'hC212, 16'h4C01, 16'h0000, 16'h0000, 16'h0080, 16'h4C03},
    '{16'h4610, 16'h3000, 16'h0000, 16'h0000, 16'h0080, 16'h4C00}};
  // Bypass maps indexed by source class times four plus result class
  localparam logic [15:0] dly_map = 16'h5A48;
  localparam logic [15:0] xfer_map = 16'h591E;

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  edw_sched_model edw_sched_model_i (.core_clk, .rst_b, .want, .hold, .req_valid, .req_op,
    .req_cls, .req_lat, .req_src_cls, .req_src_load, .req_denorm);

  edw_dispatch edw_dispatch_i (.core_clk, .rst_b, .req_valid, .req_op, .req_cls, .req_lat,
    .req_src_cls, .req_src_load, .req_denorm, .flush_underflow_to_zero,
    .denormal_inputs_as_zero, .issue, .hold, .illegal, .wb_bus, .issue_count, .byp_dly, .xfer,
    .xfer_port, .assist);

  // ========
  // Reference functions
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // Stack of a class: also the load delay seen by that class
  function automatic logic [1:0] stk(logic [1:0] c);
    return (c == 2'h0) ? 2'h0 : (c == 2'h3) ? 2'h2 : 2'h1;
  endfunction

  task automatic clear_ref();
    slot = '{default: '0};
    {e_issue, e_hold, e_ill, e_xfer, e_assist, e_dly, e_bus, e_xp} = '0;
  endtask

  // Expected answer to the request offered before this edge
  task automatic predict();
    logic [1:0] s;
    logic [2:0] l;
    logic [3:0] i;
    logic       ok;
    if (rst_b !== 1'b1)
      clear_ref();
    else
    begin
      for (int p = 0; p < 6; p++)
      begin
        s = stk(req_cls[p]);
        l = (req_lat[p] == 3'h0) ? 3'h1 : req_lat[p];
        i = {req_src_cls[p], req_cls[p]};
        ok = cap_tbl[req_cls[p][1] ? 2'h2 : req_cls[p]][p][req_op[p]];
        e_ill[p] = req_valid[p] & !ok;
        e_hold[p] = req_valid[p] & ok & slot[p][s][l];
        e_issue[p] = req_valid[p] & ok & !slot[p][s][l];
        if (e_issue[p])
          slot[p][s][l] = 1'b1;
        for (int k = 0; k < 3; k++)
          slot[p][k] = slot[p][k] >> 1;
        e_bus[p] = 5'(p * 3 + int'(s));
        e_dly[p] = req_src_load[p] ? s : {1'b0, dly_map[i]};
        e_xfer[p] = e_issue[p] & !req_src_load[p] & xfer_map[i];
        e_xp[p] = (req_src_cls[p] == 2'h0) ? 3'h0 : 3'h5;
        e_assist[p] = e_issue[p] & req_cls[p][1] & req_denorm[p] & !flush_underflow_to_zero
          & !denormal_inputs_as_zero & !(req_op[p] inside {4'h4, 4'h9, 4'hC, 4'hD});
      end
    end
  endtask

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Outputs are compared mid-cycle, long after the edge has settled
  always @(negedge core_clk)
  begin
    chk(issue, e_issue);
    chk(hold, e_hold);
    chk(illegal, e_ill);
    chk(issue_count, $countones(e_issue));
    chk(byp_dly, e_dly);
    chk(xfer, e_xfer);
    chk(assist, e_assist);
    for (int p = 0; p < 6; p++)
    begin
      if (e_issue[p])
        chk(wb_bus[p], e_bus[p]);
      if (e_xfer[p])
        chk(xfer_port[p], e_xp[p]);
    end
  end

  // ========
  // Stimulus tasks
  task automatic tick();
    @(posedge core_clk);
    predict();
  endtask

  // Reset is driven low just after an edge and stays low over exactly the next eight rising edges
  task automatic do_reset();
    rst_b <= 1'b0;
    clear_ref();
    repeat (8) tick();
    rst_b <= 1'b1;
  endtask

  // Float multiply of five cycles on port 0, then a one-cycle op four cycles later
  // Lanes are already idle on entry; every drive is made just after a rising edge
  task automatic pair(logic [3:0] op, logic [1:0] c, logic h);
    tick();
    want[0] <= {1'b1, 4'h4, 2'h2, 3'h5, 4'h0};
    tick();
    want <= '0;
    repeat (3) tick();
    want[0] <= {1'b1, op, c, 3'h1, 4'h0};
    tick();
    want <= '0;
    @(negedge core_clk);
    chk(hold[0], h);
    chk(issue[0], !h);
    tick();
    @(negedge core_clk);
    chk(issue[0], h);
  endtask

  // Every op and class on all six ports at once, or random lanes
  task automatic run(int n, logic sweep);
    logic [15:0] r;
    for (int k = 0; k < n; k++)
    begin
      tick();
      for (int p = 0; p < 6; p++)
      begin
        r = rnd();
        if (sweep)
          want[p] <= {1'b1, k[3:0], k[5:4], r[2:0], r[4:3], r[5], r[6]};
        else
          want[p] <= {r[0] | r[1], r[5:2], r[7:6], r[10:8], r[12:11], r[13] & r[14], r[15]};
      end
      r = rnd();
      flush_underflow_to_zero <= r[0] & r[1] & !sweep;
      denormal_inputs_as_zero <= r[2] & r[3] & !sweep;
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ========
  // Main sequence
  initial
  begin
    clear_ref();
    do_reset();
    pair(4'hA, 2'h2, 1'b1);
    pair(4'h0, 2'h0, 1'b0);
    run(64, 1'b1);
    run(3000, 1'b0);
    do_reset();
    run(300, 1'b0);
    final_report();
  end
endmodule
